// ---- flow_cal_ctrl.sv ----
// flow meter calibration controller: pulse scaling, totals, calibration machine
// assumes pulse and keys are raw pins; nv storage answers the same cycle
//
// Contract
// RL1: each flow pulse adds the active factor to measured volume
// RL2: factory factor is fixed at one (1000 milli-units)
// RL3: long calibration-key press in standby enters calibration mode
// RL4: no normal dispensing accounting during calibration
// RL5: neither total increments during calibration
// RL6: factor and totals are kept in non-volatile storage
// RL7: on entry show active factor and its factory/user origin
// RL8: reset-key press on factor display toggles user/factory selection
// RL9: short calibration-key press confirms; restart then applies it
// RL10: confirming factory factor erases the stored user factor
// RL11: long reset-key press enters field calibration, partial cleared
// RL12: field calibration accumulates scaled pulses across pauses
// RL13: short reset-key press ends dispensing, shows direction arrow
// RL14: further short reset-key presses reverse the arrow
// RL15: short calibration-key press steps value one unit by arrow
// RL16: held calibration key steps slowly five units, then fast
// RL17: reset-key press of one second or more is long
// RL18: long reset-key press computes, shows new factor, restarts
// RL19: slow and fast step intervals are constants, fast shorter
// RL20: keys debounced and classified short or long first
`timescale 1ns/1ps
`include "flow_cal_params.svh"
module flow_cal_ctrl
   import flow_cal_pkg::*;
#(
   parameter int LONG_CYC = `LONG_PRESS_CYC,
   parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
   parameter int SLOW_CYC = `SLOW_STEP_CYC,
   parameter int FAST_CYC = `FAST_STEP_CYC,
   parameter int SHOW_CYC = `LONG_PRESS_CYC
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pulse_raw,
   input wire logic reset_key_raw,
   input wire logic cal_key_raw,
   input wire logic [`FACTOR_W-1:0] nv_user_factor,
   input wire logic nv_user_valid,
   input wire logic [`COUNT_W-1:0] nv_total,
   input wire logic [`COUNT_W-1:0] nv_reset_total,
   output logic [`COUNT_W-1:0] partial,
   output logic [`COUNT_W-1:0] total,
   output logic [`COUNT_W-1:0] reset_total,
   output logic [`FACTOR_W-1:0] shown_factor,
   output logic show_factor,
   output logic origin_user,
   output logic cal_icon,
   output logic field_icon,
   output logic arrow_on,
   output logic arrow_up,
   output logic nv_factor_we,
   output logic nv_factor_erase,
   output logic [`FACTOR_W-1:0] nv_factor_data,
   output logic nv_totals_we
);
   //--------------------------------------------------
   // keys and pulse input
   //--------------------------------------------------
   logic reset_held;
   logic reset_short;
   logic reset_long;
   logic cal_held;
   logic cal_short;
   logic cal_long;
   logic [2:0] pulse_sync;
   logic pulse_level;
   logic pulse_edge;
   cal_state_t state;
   logic loaded;
   logic [`FACTOR_W-1:0] active_factor;
   logic factor_is_user;
   logic sel_user;
   logic [`COUNT_W-1:0] counted;
   logic [24:0] rep_cnt;
   logic [2:0] rep_units;
   logic step_now;
   logic [24:0] show_cnt;
   logic [`COUNT_W+`FACTOR_W-1:0] quot_num;

   key_classifier #(
      .DEBOUNCE(DEBOUNCE_CYC),
      .LONG(LONG_CYC)
   ) reset_key (
      .core_clk(core_clk),
      .rst(rst),
      .key_raw(reset_key_raw),
      .held(reset_held),
      .short_press(reset_short),
      .long_press(reset_long)
   );

   key_classifier #(
      .DEBOUNCE(DEBOUNCE_CYC),
      .LONG(LONG_CYC)
   ) cal_key (
      .core_clk(core_clk),
      .rst(rst),
      .key_raw(cal_key_raw),
      .held(cal_held),
      .short_press(cal_short),
      .long_press(cal_long)
   );

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         pulse_sync <= 3'h0;
         pulse_level <= 1'b0;
      end
      else
      begin
         pulse_sync <= {pulse_sync[1:0], pulse_raw};
         if (pulse_sync[2] == pulse_sync[1])
            pulse_level <= pulse_sync[2];
      end

   assign pulse_edge = (pulse_sync[2] == pulse_sync[1]) && pulse_sync[2] && !pulse_level;

   //--------------------------------------------------
   // restart: load factor and totals from storage
   //--------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         loaded <= 1'b0;
         active_factor <= `FACTORY_FACTOR;
         factor_is_user <= 1'b0;
      end
      else if (!loaded && !nv_factor_erase) // reload only once an erase has landed
      begin
         loaded <= 1'b1;
         // stored user factor applied after restart [RL9] [RL6]
         active_factor <= nv_user_valid ? nv_user_factor : `FACTORY_FACTOR; // [RL2]
         factor_is_user <= nv_user_valid;
      end
      else if (state == ST_SELECT && cal_short
               || state == ST_SHOW && show_cnt == 25'(SHOW_CYC - 1))
         loaded <= 1'b0; // restart cycle applies confirmed choice [RL9] [RL18]

   //--------------------------------------------------
   // calibration state machine
   //--------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         state <= ST_STANDBY;
      else if (!loaded)
         state <= ST_STANDBY;
      else
         case (state)
            ST_STANDBY:
               if (cal_long)
                  state <= ST_SELECT; // [RL3]
            ST_SELECT:
               if (cal_short)
                  state <= ST_STANDBY; // [RL9]
               else if (reset_long)
                  state <= ST_FIELD; // [RL11]
            ST_FIELD:
               if (reset_short)
                  state <= ST_ADJUST; // [RL13]
            ST_ADJUST:
               if (reset_long)
                  state <= ST_COMPUTE; // [RL18]
            ST_COMPUTE:
               state <= ST_SHOW;
            ST_SHOW:
               state <= ST_SHOW;
            default:
               state <= ST_STANDBY;
         endcase

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         show_cnt <= 25'h0;
      else if (state == ST_SHOW)
         show_cnt <= show_cnt + 25'h1;
      else
         show_cnt <= 25'h0;

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         sel_user <= 1'b0;
      else if (state == ST_STANDBY && cal_long)
         sel_user <= factor_is_user;
      else if (state == ST_SELECT && reset_short)
         sel_user <= !sel_user; // [RL8]

   //--------------------------------------------------
   // auto-repeat for held calibration key
   //--------------------------------------------------
   // slow period first five units, then fast [RL16] [RL19]
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         rep_cnt <= 25'h0;
         rep_units <= 3'h0;
      end
      else if (state != ST_ADJUST || !cal_held)
      begin
         rep_cnt <= 25'h0;
         rep_units <= 3'h0;
      end
      else if (cal_long || rep_cnt != 25'h0)
      begin
         if (step_now)
         begin
            rep_cnt <= 25'h1;
            if (rep_units != 3'(`SLOW_UNITS))
               rep_units <= rep_units + 3'h1;
         end
         else
            rep_cnt <= rep_cnt + 25'h1;
      end

   assign step_now = state == ST_ADJUST && cal_held && (cal_long
      || (rep_units != 3'(`SLOW_UNITS) && rep_cnt == 25'(SLOW_CYC))
      || (rep_units == 3'(`SLOW_UNITS) && rep_cnt == 25'(FAST_CYC)));

   //--------------------------------------------------
   // measured volume, partial and totals
   //--------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         partial <= '0;
         total <= '0;
         reset_total <= '0;
         nv_totals_we <= 1'b0;
         counted <= '0;
      end
      else
      begin
         nv_totals_we <= 1'b0;
         if (!loaded)
         begin
            total <= nv_total; // [RL6]
            reset_total <= nv_reset_total;
         end
         else if (state == ST_STANDBY && pulse_edge)
         begin
            partial <= partial + `COUNT_W'(active_factor); // [RL1]
            total <= total + `COUNT_W'(active_factor);
            reset_total <= reset_total + `COUNT_W'(active_factor);
            nv_totals_we <= 1'b1; // [RL6]
         end
         else if (state == ST_STANDBY && reset_short)
            partial <= '0;
         else if (state == ST_SELECT && reset_long)
            partial <= '0; // [RL11]
         else if (state == ST_FIELD && pulse_edge)
            partial <= partial + `COUNT_W'(active_factor); // [RL4] [RL5] [RL12]
         else if (state == ST_FIELD && reset_short)
            counted <= partial; // [RL13]
         else if (state == ST_ADJUST && (cal_short || step_now))
         begin
            // one unit per step by arrow [RL15] [RL16]
            if (arrow_up)
               partial <= partial + `COUNT_W'(1);
            else if (partial != '0)
               partial <= partial - `COUNT_W'(1);
         end
      end

   //--------------------------------------------------
   // display flags, arrow and factor storage
   //--------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         arrow_on <= 1'b0;
         arrow_up <= 1'b1;
      end
      else if (state == ST_FIELD && reset_short)
      begin
         arrow_on <= 1'b1; // [RL13]
         arrow_up <= 1'b1;
      end
      else if (state == ST_ADJUST && reset_short)
         arrow_up <= !arrow_up; // [RL14]
      else if (state != ST_ADJUST)
         arrow_on <= 1'b0;

   assign quot_num = `COUNT_W'(counted) * `FACTOR_W'(active_factor);

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         shown_factor <= `FACTORY_FACTOR;
         nv_factor_we <= 1'b0;
         nv_factor_erase <= 1'b0;
         nv_factor_data <= `FACTORY_FACTOR;
      end
      else
      begin
         nv_factor_we <= 1'b0;
         nv_factor_erase <= state == ST_SELECT && cal_short && !sel_user; // [RL10]
         if (state == ST_STANDBY && cal_long)
            shown_factor <= active_factor; // [RL7]
         else if (state == ST_SELECT && reset_short)
            shown_factor <= sel_user ? `FACTORY_FACTOR : nv_user_factor; // [RL8]
         else if (state == ST_COMPUTE)
         begin
            // new factor = old * counted / indicated [RL18]
            if (partial != '0)
            begin
               shown_factor <= `FACTOR_W'(quot_num / partial);
               nv_factor_data <= `FACTOR_W'(quot_num / partial);
            end
            else
               nv_factor_data <= active_factor;
            nv_factor_we <= 1'b1; // [RL6]
         end
      end

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         show_factor <= 1'b0;
         origin_user <= 1'b0;
         cal_icon <= 1'b0;
         field_icon <= 1'b0;
      end
      else
      begin
         show_factor <= state == ST_SELECT || state == ST_SHOW; // [RL7]
         origin_user <= state == ST_SELECT ? sel_user : factor_is_user;
         cal_icon <= state != ST_STANDBY;
         field_icon <= state == ST_FIELD || state == ST_ADJUST; // [RL11]
      end

   //--------------------------------------------------
   // checks
   //--------------------------------------------------
   a_totals_frozen: assert property (@(posedge core_clk) disable iff (rst) // [RL5]
      loaded && state != ST_STANDBY |=> $stable(total) && $stable(reset_total))
      else $error("total moved in calibration");
   a_cal_entry: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
      loaded && state == ST_STANDBY && cal_long |=> state == ST_SELECT)
      else $error("long cal press did not enter calibration");
   a_pulse_weight: assert property (@(posedge core_clk) disable iff (rst) // [RL1]
      loaded && state == ST_STANDBY && pulse_edge
      |=> partial == $past(partial) + `COUNT_W'(active_factor))
      else $error("pulse not scaled by factor");
   a_field_clear: assert property (@(posedge core_clk) disable iff (rst) // [RL11]
      loaded && state == ST_SELECT && reset_long |=> partial == '0 ##1 field_icon)
      else $error("field entry did not clear partial");
   a_arrow_flip: assert property (@(posedge core_clk) disable iff (rst) // [RL14]
      loaded && state == ST_ADJUST && reset_short |=> arrow_up != $past(arrow_up))
      else $error("arrow not reversed");
   a_factory_erase: assert property (@(posedge core_clk) disable iff (rst) // [RL10]
      loaded && state == ST_SELECT && cal_short && !sel_user |=> nv_factor_erase)
      else $error("user factor not erased");
   a_step_up: assert property (@(posedge core_clk) disable iff (rst) // [RL15]
      loaded && state == ST_ADJUST && cal_short && arrow_up && !reset_short
      |=> partial == $past(partial) + `COUNT_W'(1))
      else $error("short cal press did not step");
   a_select_toggle: assert property (@(posedge core_clk) disable iff (rst) // [RL8]
      loaded && state == ST_SELECT && reset_short |=> sel_user != $past(sel_user))
      else $error("selection not toggled");
   c_enter_field: cover property (@(posedge core_clk) state == ST_FIELD);
   c_fast_step: cover property (@(posedge core_clk) step_now && rep_units == 3'(`SLOW_UNITS));
   c_new_factor: cover property (@(posedge core_clk) nv_factor_we);
endmodule : flow_cal_ctrl

// ---- flow_cal_params.svh ----
// timing counts, reset values and field widths of the flow meter calibration controller
// assumes a 20 MHz core clock
`ifndef FLOW_CAL_PARAMS_SVH
`define FLOW_CAL_PARAMS_SVH
`define CLK_HZ 20000000
`define FACTOR_W 16
`define COUNT_W 32
`define FACTORY_FACTOR 16'h03E8
`define LONG_PRESS_MS 1000
`define LONG_PRESS_CYC ((`CLK_HZ / 1000) * `LONG_PRESS_MS)
`define DEBOUNCE_US 10000
`define DEBOUNCE_CYC ((`CLK_HZ / 1000000) * `DEBOUNCE_US)
`define SLOW_STEP_MS 400
`define SLOW_STEP_CYC ((`CLK_HZ / 1000) * `SLOW_STEP_MS)
`define FAST_STEP_MS 100
`define FAST_STEP_CYC ((`CLK_HZ / 1000) * `FAST_STEP_MS)
`define SLOW_UNITS 5
`endif

// ---- flow_cal_pkg.sv ----
// types of the flow meter calibration controller
// used by the controller and the bench; the key classifier does not import it
package flow_cal_pkg;
   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b000,
      ST_SELECT = 3'b001,
      ST_FIELD = 3'b010,
      ST_ADJUST = 3'b011,
      ST_COMPUTE = 3'b100,
      ST_SHOW = 3'b101
   } cal_state_t;
endpackage : flow_cal_pkg

// ---- key_classifier.sv ----
// one push-button: synchroniser, debouncer, short/long classification
// assumes an active-high raw key level from a pin
`timescale 1ns/1ps
`include "flow_cal_params.svh"
module key_classifier #(
   parameter int DEBOUNCE = `DEBOUNCE_CYC,
   parameter int LONG = `LONG_PRESS_CYC
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic key_raw,
   output logic held,
   output logic short_press,
   output logic long_press
);
   logic [2:0] sync;
   logic [24:0] db_cnt;
   logic [24:0] hold_cnt;
   logic long_sent;

   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         sync <= 3'h0;
      else
         sync <= {sync[1:0], key_raw};

   // debounce on agreeing 2nd and 3rd stages [RL20]
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         held <= 1'b0;
         db_cnt <= 25'h0;
      end
      else if (sync[2] != sync[1] || sync[2] == held)
         db_cnt <= 25'h0;
      else if (db_cnt == 25'(DEBOUNCE - 1))
      begin
         held <= sync[2];
         db_cnt <= 25'h0;
      end
      else
         db_cnt <= db_cnt + 25'h1;

   // classify by hold duration [RL20] [RL17]
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         hold_cnt <= 25'h0;
         long_sent <= 1'b0;
         short_press <= 1'b0;
         long_press <= 1'b0;
      end
      else
      begin
         short_press <= 1'b0;
         long_press <= 1'b0;
         if (held)
         begin
            if (hold_cnt == 25'(LONG - 1) && !long_sent)
            begin
               long_press <= 1'b1;
               long_sent <= 1'b1;
            end
            else if (!long_sent)
               hold_cnt <= hold_cnt + 25'h1;
         end
         else
         begin
            if (hold_cnt != 25'h0 && !long_sent)
               short_press <= 1'b1;
            hold_cnt <= 25'h0;
            long_sent <= 1'b0;
         end
      end
endmodule : key_classifier

// ---- operator_panel_model.sv ----
// operator side of the meter: reset key, calibration key and flow pulse sensor
// assumes keys read high while pressed; drives 2 ns after each rising edge
`timescale 1ns/1ps
module operator_panel_model (
   input wire logic core_clk,
   output logic pulse_raw,
   output logic reset_key_raw,
   output logic cal_key_raw
);
   localparam int DRIVE_DLY = 2;
   localparam int GAP_CYC = 15;

   initial
   begin
      pulse_raw = 1'b0;
      reset_key_raw = 1'b0;
      cal_key_raw = 1'b0;
   end

   // ----------------------------------------------------------------
   // key and sensor tasks
   // ----------------------------------------------------------------
   task automatic step_edge;
      @(posedge core_clk);
      #DRIVE_DLY;
   endtask : step_edge

   task automatic key_set(input logic which_cal, input logic level);
      step_edge();
      if (which_cal)
         cal_key_raw = level;
      else
         reset_key_raw = level;
   endtask : key_set

   // hold a key for a number of cycles, then leave a quiet gap
   task automatic press(input logic which_cal, input int hold);
      key_set(which_cal, 1'b1);
      repeat (hold) step_edge();
      key_set(which_cal, 1'b0);
      repeat (GAP_CYC) step_edge();
   endtask : press

   // rotor pulses, wide enough for the input synchroniser
   task automatic flow(input int n);
      repeat (n)
      begin
         step_edge();
         pulse_raw = 1'b1;
         repeat (4) step_edge();
         pulse_raw = 1'b0;
         repeat (4) step_edge();
      end
   endtask : flow
endmodule : operator_panel_model

// ---- test_flow_meter_calibration_ctrl.sv ----
// self-checking bench of the calibration controller
// assumes shortened key and step counts; storage is modelled here
`timescale 1ns/1ps
`include "flow_cal_params.svh"
module test_flow_meter_calibration_ctrl;
   import flow_cal_pkg::*;
   localparam int SLOW = 20;
   localparam int FAST = 5;
   localparam int SHORT_HOLD = 20;
   localparam int LONG_HOLD = 70;
   localparam logic [31:0] F_USER = 32'h000003DE;
   localparam logic [31:0] F_FACT = 32'h000003E8;
   localparam logic [31:0] T_BOOT = 32'h00000100;
   localparam logic [31:0] R_BOOT = 32'h00000080;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic pulse_raw, reset_key_raw, cal_key_raw;
   logic [`FACTOR_W-1:0] nv_user_factor;
   logic nv_user_valid;
   logic [`COUNT_W-1:0] nv_total;
   logic [`COUNT_W-1:0] nv_reset_total;
   logic [`COUNT_W-1:0] partial, total, reset_total;
   logic [`FACTOR_W-1:0] shown_factor, nv_factor_data;
   logic show_factor, origin_user, cal_icon, field_icon, arrow_on, arrow_up;
   logic nv_factor_we, nv_factor_erase, nv_totals_we;
   int errors = 0;
   int checks_done = 0;
   int erase_seen = 0;
   int store_seen = 0;

   always #25 core_clk = ~core_clk;

   operator_panel_model panel (.core_clk(core_clk), .pulse_raw(pulse_raw),
      .reset_key_raw(reset_key_raw), .cal_key_raw(cal_key_raw));

   flow_cal_ctrl #(.LONG_CYC(50), .DEBOUNCE_CYC(4), .SLOW_CYC(SLOW), .FAST_CYC(FAST),
      .SHOW_CYC(30)) DUT (.core_clk(core_clk), .rst(rst), .pulse_raw(pulse_raw),
      .reset_key_raw(reset_key_raw), .cal_key_raw(cal_key_raw),
      .nv_user_factor(nv_user_factor), .nv_user_valid(nv_user_valid),
      .nv_total(nv_total), .nv_reset_total(nv_reset_total), .partial(partial),
      .total(total), .reset_total(reset_total), .shown_factor(shown_factor),
      .show_factor(show_factor), .origin_user(origin_user), .cal_icon(cal_icon),
      .field_icon(field_icon), .arrow_on(arrow_on), .arrow_up(arrow_up),
      .nv_factor_we(nv_factor_we), .nv_factor_erase(nv_factor_erase),
      .nv_factor_data(nv_factor_data), .nv_totals_we(nv_totals_we));

   // ----------------------------------------------------------------
   // non-volatile storage model
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         // contents found at power-up: a user factor and nonzero totals
         nv_user_factor <= F_USER[15:0];
         nv_user_valid <= 1'b1;
         nv_total <= T_BOOT;
         nv_reset_total <= R_BOOT;
      end
      if (nv_factor_erase === 1'b1)
      begin
         nv_user_valid <= 1'b0;
         erase_seen++;
      end
      if (nv_factor_we === 1'b1)
      begin
         nv_user_factor <= nv_factor_data;
         nv_user_valid <= 1'b1;
      end
      if (nv_totals_we === 1'b1)
      begin
         nv_total <= total;
         nv_reset_total <= reset_total;
         store_seen++;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic tick;
      @(posedge core_clk);
      #2;
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      $display("BAD %0t run did not finish", $time);
      finish_test();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   logic [31:0] exp_total, prev, ind, kf;
   int t[16];
   int n, c;
   initial
   begin
      repeat (6) tick();
      chk(shown_factor, F_FACT, "factory factor at reset");
      chk(arrow_up, 1, "arrow at reset");
      repeat (6) tick();
      rst <= 1'b0;
      repeat (5) tick();
      panel.flow(3);
      repeat (5) tick();
      exp_total = T_BOOT + 3 * F_USER;
      chk(total, exp_total, "stored total restored and scaled");
      chk(reset_total, R_BOOT + 3 * F_USER, "reset total restored and scaled");
      chk(store_seen > 0, 1, "totals stored");
      panel.press(1'b1, SHORT_HOLD);
      chk(show_factor, 0, "short cal key in standby");
      panel.press(1'b1, LONG_HOLD);
      chk({show_factor, cal_icon, origin_user}, 3'b111, "factor page");
      chk(shown_factor, F_USER, "active user factor shown");
      panel.flow(2);
      repeat (5) tick();
      chk(total, exp_total, "total frozen in calibration");
      panel.press(1'b0, SHORT_HOLD);
      chk(shown_factor, F_FACT, "toggle to factory");
      panel.press(1'b0, SHORT_HOLD);
      chk(shown_factor, F_USER, "toggle to user");
      panel.press(1'b0, SHORT_HOLD);
      chk(shown_factor, F_FACT, "toggle to factory again");
      panel.press(1'b1, SHORT_HOLD);
      chk(erase_seen, 1, "user factor erased");
      chk({show_factor, cal_icon}, 2'b00, "back in standby");
      panel.flow(1);
      repeat (5) tick();
      exp_total = exp_total + F_FACT;
      chk(total, exp_total, "factory factor applied");
      panel.press(1'b1, LONG_HOLD);
      chk({show_factor, origin_user, shown_factor}, {2'b10, F_FACT[15:0]}, "fact page");
      panel.press(1'b0, LONG_HOLD);
      chk({cal_icon, field_icon}, 2'b11, "field page");
      chk(partial, 0, "partial cleared");
      panel.flow(2);
      repeat (30) tick();
      panel.flow(3);
      repeat (5) tick();
      chk(partial, 5 * F_FACT, "field count over pauses");
      chk(total, exp_total, "totals frozen in field");
      panel.press(1'b0, SHORT_HOLD);
      chk({arrow_on, arrow_up}, 2'b11, "arrow shown");
      chk(partial, 5 * F_FACT, "counted value kept");
      panel.press(1'b1, SHORT_HOLD);
      chk(partial, 5 * F_FACT + 1, "one unit up");
      panel.press(1'b0, SHORT_HOLD);
      chk(arrow_up, 0, "arrow reversed");
      panel.press(1'b1, SHORT_HOLD);
      chk(partial, 5 * F_FACT, "one unit down");
      panel.press(1'b0, SHORT_HOLD);
      chk(arrow_up, 1, "arrow reversed back");
      panel.key_set(1'b1, 1'b1);
      prev = partial;
      n = 0;
      for (c = 0; c < 700 && n < 16; c++)
      begin
         tick();
         if (partial !== prev)
         begin
            chk(partial, prev + 1, "held step size");
            t[n] = c;
            n++;
            prev = partial;
            if (n == 10)
               panel.key_set(1'b1, 1'b0);
         end
      end
      chk(n >= 10, 1, "held key keeps stepping");
      for (c = 0; c < 4; c++)
         chk(t[c + 1] - t[c], SLOW, "slow step interval");
      for (c = 4; c < 9; c++)
         chk(t[c + 1] - t[c], FAST, "fast step interval");
      ind = 5 * F_FACT + n;
      kf = (F_FACT * 5 * F_FACT) / ind;
      panel.key_set(1'b0, 1'b1);
      for (c = 0; c < 300 && nv_factor_we !== 1'b1; c++)
         tick();
      chk(nv_factor_we, 1, "new factor written");
      chk(nv_factor_data == kf || nv_factor_data == kf + 1, 1, "new factor value");
      kf = {16'h0000, nv_factor_data};
      panel.key_set(1'b0, 1'b0);
      chk({show_factor, shown_factor}, {1'b1, kf[15:0]}, "new factor shown");
      repeat (80) tick();
      chk({cal_icon, arrow_on}, 2'b00, "restart to standby");
      panel.flow(1);
      repeat (5) tick();
      chk(total, exp_total + kf, "new user factor applied");
      finish_test();
   end
endmodule : test_flow_meter_calibration_ctrl
